// *** dv/itm_bus_sink.sv ***
module itm_bus_sink (
	// Telegram requests from the block
	input wire logic       clk,
	input wire logic       valueSend,
	input wire logic [1:0] stateSend,
	// Telegram tallies
	output int             valCnt,
	output int             st0Cnt,
	output int             st1Cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	// The bus takes every telegram; the tallies let the bench see silence.
	initial begin
		valCnt = 0;
		st0Cnt = 0;
		st1Cnt = 0;
	end
	always @(posedge clk) begin
		if (valueSend) valCnt <= valCnt + 1;
		if (stateSend[0]) st0Cnt <= st0Cnt + 1;
		if (stateSend[1]) st1Cnt <= st1Cnt + 1;
	end
endmodule // itm_bus_sink

// *** dv/itm_monitor_props.sv ***
module itm_monitor_props (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Telegrams and interrupt
	input wire logic        valueSend,
	input wire logic [1:0]  stateSend,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("no write answer");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid) else $error("write answer dropped");
	a_busy_refuse: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready) else $error("taken while busy");
	a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
	a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr > 8'h20 |=> s_axi_rvalid && s_axi_rresp == 2'h2 &&
		s_axi_rdata == 32'h0000_0000) else $error("bad unmapped read");
	a_value_spaced: assert property (valueSend |=> !valueSend [*8])
		else $error("value telegrams too close");
	a_state_pulse: assert property (stateSend != 2'h0 |=>
		stateSend == 2'h0) else $error("state pulse too long");
	a_reset_quiet: assert property (disable iff (1'b0) rst |=> !valueSend &&
		stateSend == 2'h0 && !irq && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs busy after reset");

	cover property (valueSend);
	cover property (stateSend[1]);
	cover property (irq);
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // itm_monitor_props

// *** dv/tb_irradiance_threshold_monitor.sv ***
module tb_irradiance_threshold_monitor;
	timeunit 1ns;
	timeprecision 1ps;
	import itm_pkg::*;
	logic        clk, valueSend, irq, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        rst = 1'b1, sampleValid = 1'b0, s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [1:0]  s_axi_bresp, s_axi_rresp, stateSend, stateData, rsp;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [15:0] irradiance = 16'h0000, valueData, b;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rdv;
	int          fail_count = 0, total_checks = 0, valCnt, st0Cnt, st1Cnt;
	int          n, c0;

	itm_monitor #(.TICK_CYCLES_P(10)) i_itm_monitor (.*);
	itm_bus_sink i_itm_bus_sink (.*);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic tmo();
		fail_count++;
		$display("MISMATCH %0t wait ran out", $time);
		complete_run();
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic win(input int g, input int lo, input int hi);
		total_checks++;
		if (g < lo || g > hi) begin
			fail_count++;
			$display("MISMATCH %0t cycles %0d", $time, g);
		end
	endtask

	// Readies are sampled on the falling edge, where nothing is moving.
	task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		bit ta, tw, tr, dn;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		for (k = 0; k < 40; k++) begin
			@(negedge clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tr = s_axi_arvalid && s_axi_arready;
			dn = wr ? s_axi_bvalid : s_axi_rvalid;
			rdv = s_axi_rdata;
			rsp = wr ? s_axi_bresp : s_axi_rresp;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tr) s_axi_arvalid <= 1'b0;
			if (dn) break;
		end
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		if (k == 40) tmo();
	endtask

	task automatic smp(input logic [15:0] v);
		@(posedge clk);
		irradiance <= v;
		sampleValid <= 1'b1;
		@(posedge clk);
		sampleValid <= 1'b0;
	endtask

	task automatic waitp(input int s, input int lim, input bit must);
		for (n = 0; n < lim; n++) begin
			@(negedge clk);
			if (s == 0 ? valueSend : stateSend[s - 1]) break;
		end
		@(posedge clk);
		if (must && n == lim) tmo();
	endtask

	task automatic regs();
		axi(0, ADR_CTRL, 32'h0000_0000);
		chk(rdv, CTRL_RST);
		axi(0, ADR_CH0, 32'h0000_0000);
		chk(rdv, CH_RST);
		axi(0, ADR_MASK, 32'h0000_0000);
		chk(rdv, MASK_RST);
		axi(0, 8'h24, 32'h0000_0000);
		chk({30'h0, rsp}, 32'h0000_0002);
		axi(1, ADR_STAT, 32'h0000_0001);
		chk({30'h0, rsp}, 32'h0000_0000);
		$display("registers done");
	endtask

	// Steps are the four fractions of a 2000 W/m2 range.
	task automatic diffs();
		int st [4] = '{10, 20, 60, 200};
		b = 16'h0000;
		for (int k = 0; k < 4; k++) begin
			axi(1, ADR_CTRL, 32'(k) << 2);
			smp(b + 16'(st[k]) - 16'h0001);
			waitp(0, 130, 0);
			win(n, 130, 130);
			b = b + 16'(st[k]) + 16'h0001;
			smp(b);
			waitp(0, 130, 1);
			win(n, 88, 112);
			chk({16'h0, valueData}, {16'h0, b});
		end
		$display("difference sends done");
	endtask

	task automatic cyclic();
		axi(1, ADR_CTRL, 32'h0000_001C);
		waitp(0, 130, 1);
		waitp(0, 130, 1);
		win(n, 95, 105);
		chk({16'h0, valueData}, {16'h0, irradiance});
		c0 = valCnt;
		smp(irradiance + 16'h012C);
		repeat (400) @(posedge clk);
		win(valCnt - c0, 4, 5);
		$display("cyclic sends done");
	endtask

	task automatic chan();
		smp(16'h00C8);
		axi(1, ADR_CTRL, 32'h0000_000D);
		axi(1, ADR_CH1, 32'h0020_0200);
		axi(1, ADR_CH0, 32'h0020_0212);
		axi(1, ADR_MASK, 32'h0000_0002);
		smp(16'h01F5);
		waitp(1, 40, 1);
		chk({31'h0, stateData[0]}, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0000_0001);
		axi(1, ADR_IRQ, 32'h0000_0002);
		chk({31'h0, irq}, 32'h0000_0000);
		smp(16'h015F);
		waitp(1, 40, 0);
		win(n, 40, 40);
		smp(16'h015D);
		waitp(1, 40, 1);
		chk({31'h0, stateData[0]}, 32'h0000_0000);
		smp(16'h02BC);
		waitp(1, 40, 1);
		axi(1, ADR_CH0, 32'h0020_00D2);
		repeat (40) @(posedge clk);
		smp(16'h01F3);
		waitp(1, 40, 1);
		chk({31'h0, stateData[0]}, 32'h0000_0000);
		smp(16'h0289);
		waitp(1, 40, 0);
		win(n, 40, 40);
		smp(16'h028B);
		waitp(1, 40, 1);
		chk({31'h0, stateData[0]}, 32'h0000_0001);
		$display("threshold channel done");
	endtask

	task automatic delays();
		axi(1, ADR_CH0, 32'h0024_6212);
		smp(16'h015D);
		waitp(1, 80, 1);
		win(n, 20, 42);
		smp(16'h01F5);
		waitp(1, 100, 1);
		win(n, 40, 62);
		chk({31'h0, stateData[0]}, 32'h0000_0001);
		$display("delays done");
	endtask

	task automatic quiet();
		axi(1, ADR_CH0, 32'h0060_0412);
		waitp(1, 130, 1);
		chk({31'h0, stateData[0]}, 32'h0000_0001);
		smp(16'h015D);
		waitp(1, 250, 0);
		win(n, 250, 250);
		axi(1, ADR_CH0, 32'h0000_0212);
		smp(16'h01F5);
		waitp(1, 150, 0);
		win(n, 150, 150);
		axi(0, ADR_STAT, 32'h0000_0000);
		chk({31'h0, rdv[0]}, 32'h0000_0001);
		$display("suppression done");
	endtask

	// The external party writes 400 W/m2, below the field level of 500.
	task automatic ext();
		for (int k = 1; k < 3; k++) begin
			axi(1, ADR_EXT0, k == 1 ? 32'h0000_0190 : 32'h0000_0028);
			axi(1, ADR_CH0, 32'h0020_0202 | (32'(k) << 11));
			smp(16'h012C);
			waitp(1, 40, 0);
			smp(16'h0191);
			waitp(1, 40, 1);
			chk({31'h0, stateData[0]}, 32'h0000_0001);
		end
		$display("external level done");
	endtask

	task automatic twoch();
		chk(32'(st1Cnt), 32'h0000_0000);
		axi(1, ADR_CTRL, 32'h0000_000E);
		waitp(2, 40, 1);
		chk({31'h0, stateData[1]}, 32'h0000_0001);
		$display("second channel done");
	endtask

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		regs();
		diffs();
		cyclic();
		chan();
		delays();
		quiet();
		ext();
		twoch();
		complete_run();
	end
endmodule // tb_irradiance_threshold_monitor

bind itm_monitor itm_monitor_props i_itm_monitor_props (.*);

// *** rtl/itm_monitor.sv ***
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
module itm_monitor #(
	parameter int unsigned TICK_CYCLES_P = itm_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Measurement from the acquisition logic
	input  wire logic [15:0] irradiance,
	input  wire logic        sampleValid,
	// Telegram requests
	output logic             valueSend,
	output logic [15:0]      valueData,
	output logic [1:0]       stateSend,
	output logic [1:0]       stateData,
	// Interrupt
	output logic             irq
);
	import itm_pkg::*;

	logic [31:0] ctrl_q, mask_q, stat_q;
	logic [31:0] chReg_q [2];
	logic [15:0] ext_q [2];
	logic [15:0] value_q, lastSent_q;
	logic        awSeen_q, wSeen_q, bvalid_q, rvalid_q;
	logic [7:0]  awAddr_q;
	logic [31:0] wData_q, rdata_q;
	logic [3:0]  wStrb_q;
	logic        rOk_q, bOk_q;

	// Write channel: address and data may arrive in either order.
	assign s_axi_awready = !awSeen_q && !bvalid_q;
	assign s_axi_wready  = !wSeen_q && !bvalid_q;
	wire awTake = s_axi_awvalid && s_axi_awready;
	wire wTake  = s_axi_wvalid && s_axi_wready;
	wire [7:0]  wAddr  = awTake ? s_axi_awaddr : awAddr_q;
	wire [31:0] wDat   = wTake ? s_axi_wdata : wData_q;
	wire [3:0]  wStb   = wTake ? s_axi_wstrb : wStrb_q;
	wire        wDo    = (awSeen_q || awTake) && (wSeen_q || wTake);
	wire        wMapped = wAddr <= ADR_MASK && wAddr[1:0] == 2'b00
		&& wAddr != ADR_STAT;
	wire [31:0] bMask = {{8{wStb[3]}}, {8{wStb[2]}},
		{8{wStb[1]}}, {8{wStb[0]}}};
	wire [31:0] wMerge_ctrl = (ctrl_q & ~bMask) | (wDat & bMask);
	wire [31:0] wMerge_ch0  = (chReg_q[0] & ~bMask) | (wDat & bMask);
	wire [31:0] wMerge_ch1  = (chReg_q[1] & ~bMask) | (wDat & bMask);
	wire [31:0] wMerge_mask = (mask_q & ~bMask) | (wDat & bMask);
	wire [31:0] irqClr = (wDo && wAddr == ADR_IRQ) ? (wDat & bMask) : '0;

	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bOk_q ? 2'b00 : 2'b10;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rOk_q ? 2'b00 : 2'b10;

	// Prescaler for the one-second base.
	logic [$clog2(TICK_CYCLES_P)-1:0] pre_q;
	wire tick = pre_q == ($clog2(TICK_CYCLES_P))'(TICK_CYCLES_P - 1);

	// Measured value path.
	itm_chsel_t chSel;
	assign chSel = itm_chsel_t'(ctrl_q[1:0]);
	wire [1:0]  diffSel  = ctrl_q[3:2];
	wire [6:0]  valCycle = ctrl_q[10:4];
	logic [15:0] diffAmt;
	always_comb begin
		case (diffSel)
			2'h0: diffAmt = RANGE_UPPER / 16'd200;
			2'h1: diffAmt = RANGE_UPPER / 16'd100;
			2'h2: diffAmt = (RANGE_UPPER * 16'd3) / 16'd100;
			default: diffAmt = RANGE_UPPER / 16'd10;
		endcase
	end
	wire [15:0] delta = value_q > lastSent_q ? value_q - lastSent_q
		: lastSent_q - value_q;
	wire diffHit = delta >= diffAmt;
	logic [3:0] holdCnt_q;
	logic       holdRun_q;
	logic [10:0] valSec_q;
	wire [10:0] valPeriod = 11'(valCycle) * 11'(CYCLE_UNIT_S);
	wire valCycHit = valCycle != 7'h00 && tick
		&& valSec_q + 11'd1 >= valPeriod;
	wire valDelDone = holdRun_q && tick
		&& holdCnt_q == 4'(SEND_DELAY_S - 1);
	wire valFire = valCycHit || valDelDone;

	// Threshold channels.
	logic [1:0] evt;
	logic [1:0] chSendNow;
	logic [1:0] accState;
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gCh
			itm_chcfg_t cfg;
			assign cfg = itm_chcfg_t'(chReg_q[g][$bits(itm_chcfg_t)-1:0]);
			wire en = (g == 0) ? chSel != ITM_CH_NONE
				: chSel == ITM_CH_TWO;
			logic [15:0] thr, hyst;
			always_comb begin
				case (cfg.extSel)
					ITM_EXT_16: thr = ext_q[g];
					ITM_EXT_8:  thr = {8'h00, ext_q[g][7:0]} * 16'd10;
					default: thr = THR_MIN
						+ 16'(cfg.levelSel > 4'hA ? 4'hA : cfg.levelSel)
						* THR_STEP;
				endcase
				case (cfg.hystSel)
					2'h1: hyst = 16'd150;
					2'h2: hyst = 16'd200;
					2'h3: hyst = 16'd250;
					default: hyst = 16'd0;
				endcase
			end
			// Crossing state: 1 after forward crossing, 0 after return.
			logic cross_q;
			wire fwd = cfg.falling ? value_q < thr : value_q > thr;
			// Widened sums: an external level near full scale must not wrap.
			wire back = cfg.falling
				? 17'(value_q) > 17'(thr) + 17'(hyst)
				: 17'(value_q) + 17'(hyst) < 17'(thr);
			wire crossD = fwd ? 1'b1 : (back ? 1'b0 : cross_q);
			itm_tg_t act;
			// Act on the fresh crossing so a new setting gives no false edge.
			assign act = crossD ? cfg.fwdTg : cfg.backTg;
			wire want = act == ITM_TG_ON;
			wire mute = act == ITM_TG_NONE;
			logic acc_q;
			logic [11:0] dly_q;
			logic [10:0] sec_q;
			wire [11:0] dlyLim = want ? itm_delay_s(cfg.onDelay)
				: itm_delay_s(cfg.offDelay);
			wire pend = en && !mute && want != acc_q;
			wire accept = pend && (dlyLim == 12'd0
				|| (tick && dly_q + 12'd1 >= dlyLim));
			wire [10:0] per = 11'(cfg.cycleCnt) * 11'(CYCLE_UNIT_S);
			wire cyc = en && !mute && cfg.cycleCnt != 7'h00 && tick
				&& sec_q + 11'd1 >= per;
			assign chSendNow[g] = (accept && cfg.sendChange)
				|| cyc;
			assign evt[g] = accept;
			assign accState[g] = accept ? want : acc_q;
			always_ff @(posedge clk) begin
				if (rst || !en) begin
					cross_q <= 1'b0;
					acc_q <= 1'b0;
					dly_q <= '0;
					sec_q <= '0;
				end else begin
					cross_q <= crossD;
					acc_q <= accState[g];
					if (!pend || accept) dly_q <= '0;
					else if (tick) dly_q <= dly_q + 12'd1;
					if (cyc || cfg.cycleCnt == 7'h00) sec_q <= '0;
					else if (tick) sec_q <= sec_q + 11'd1;
				end
			end
		end
	endgenerate

	wire [31:0] events = {29'h0, evt[1], evt[0], valFire};
	assign irq = |(stat_q & mask_q);

	logic [31:0] rMux;
	wire [7:0] ra = s_axi_araddr;
	wire rMapped = ra <= ADR_VALUE && ra[1:0] == 2'b00;
	always_comb begin
		case (ra)
			ADR_CTRL: rMux = ctrl_q;
			ADR_CH0:  rMux = chReg_q[0];
			ADR_CH1:  rMux = chReg_q[1];
			ADR_EXT0: rMux = {16'h0, ext_q[0]};
			ADR_EXT1: rMux = {16'h0, ext_q[1]};
			ADR_STAT: rMux = {30'h0, accState};
			ADR_IRQ:  rMux = stat_q;
			ADR_MASK: rMux = mask_q;
			ADR_VALUE: rMux = {16'h0, value_q};
			default:  rMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= CTRL_RST;
			chReg_q[0] <= CH_RST;
			chReg_q[1] <= CH_RST;
			ext_q[0] <= '0;
			ext_q[1] <= '0;
			mask_q <= MASK_RST;
			stat_q <= '0;
			awSeen_q <= 1'b0;
			wSeen_q <= 1'b0;
			bvalid_q <= 1'b0;
			bOk_q <= 1'b1;
			awAddr_q <= '0;
			wData_q <= '0;
			wStrb_q <= '0;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rOk_q <= 1'b1;
		end else begin
			if (wDo) begin
				awSeen_q <= 1'b0;
				wSeen_q <= 1'b0;
				bvalid_q <= 1'b1;
				bOk_q <= wMapped || wAddr == ADR_STAT;
				case (wAddr)
					ADR_CTRL: ctrl_q <= wMerge_ctrl;
					ADR_CH0:  chReg_q[0] <= wMerge_ch0;
					ADR_CH1:  chReg_q[1] <= wMerge_ch1;
					ADR_EXT0: ext_q[0] <= wDat[15:0];
					ADR_EXT1: ext_q[1] <= wDat[15:0];
					ADR_MASK: mask_q <= wMerge_mask;
					default: ;
				endcase
			end else begin
				if (awTake) awSeen_q <= 1'b1;
				if (wTake) wSeen_q <= 1'b1;
				if (awTake) awAddr_q <= s_axi_awaddr;
				if (wTake) wData_q <= s_axi_wdata;
				if (wTake) wStrb_q <= s_axi_wstrb;
			end
			if (bvalid_q && s_axi_bready) bvalid_q <= 1'b0;
			// Set wins over a simultaneous write-one clear.
			stat_q <= (stat_q & ~irqClr) | events;
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_q <= 1'b1;
				rdata_q <= rMux;
				rOk_q <= rMapped;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pre_q <= '0;
			value_q <= '0;
			lastSent_q <= '0;
			holdRun_q <= 1'b0;
			holdCnt_q <= '0;
			valSec_q <= '0;
			valueSend <= 1'b0;
			valueData <= '0;
			stateSend <= '0;
			stateData <= '0;
		end else begin
			pre_q <= tick ? '0 : pre_q + 1'b1;
			if (sampleValid) value_q <= irradiance;
			// The delay restarts nothing: a change seen while it runs rides it.
			if (diffHit && !holdRun_q) holdRun_q <= 1'b1;
			else if (valDelDone) holdRun_q <= 1'b0;
			if (!holdRun_q || valDelDone) holdCnt_q <= '0;
			else if (tick) holdCnt_q <= holdCnt_q + 4'd1;
			if (valDelDone) lastSent_q <= value_q;
			if (valCycHit || valCycle == 7'h00) valSec_q <= '0;
			else if (tick) valSec_q <= valSec_q + 11'd1;
			valueSend <= valFire;
			if (valFire) valueData <= value_q;
			stateSend <= chSendNow;
			stateData <= accState;
		end
	end
endmodule // itm_monitor

// *** rtl/itm_pkg.sv ***
// Operation
// - Config selects zero, one or two channels.
// - Send value on 0.5/1/3/10 percent change.
// - Fixed ten second delay before change send.
// - Periodic value send every N x 10 s.
// - Periodic and change sends run independently.
// - Threshold 300 to 1300 W/m2 per channel.
// - Hysteresis none, 150, 200 or 250 W/m2.
// - Rising modes: above on, below minus hyst off.
// - Falling modes: below on, above plus hyst off.
// - No-telegram condition also mutes periodic sends.
// - External 16-bit or 8-bit threshold object.
// - Switch-on delay; periodic reports zero meanwhile.
// - Switch-off delay; periodic reports one meanwhile.
// - Change send disabled: no telegram on change.
// - Change send enabled: telegram every accepted edge.
// - Periodic state send every N x 10 s.
// - Both disabled: state never sent.
package itm_pkg;
	localparam int unsigned CLK_HZ      = 125_000_000;
	localparam int unsigned TICK_NS     = 1_000_000_000;
	localparam int unsigned CLK_NS      = 8;
	localparam int unsigned TICK_CYCLES = TICK_NS / CLK_NS;
	localparam int unsigned SEND_DELAY_S = 10;
	localparam int unsigned CYCLE_UNIT_S = 10;
	localparam logic [6:0]  CYCLE_MAX    = 7'h78;
	localparam logic [15:0] RANGE_UPPER  = 16'h0000 + 16'd2000;
	localparam logic [15:0] THR_MIN      = 16'd300;
	localparam logic [15:0] THR_MAX      = 16'd1300;
	localparam logic [15:0] THR_STEP     = 16'd100;
	// AXI4-Lite register byte addresses.
	localparam logic [7:0] ADR_CTRL   = 8'h00;
	localparam logic [7:0] ADR_CH0    = 8'h04;
	localparam logic [7:0] ADR_CH1    = 8'h08;
	localparam logic [7:0] ADR_EXT0   = 8'h0C;
	localparam logic [7:0] ADR_EXT1   = 8'h10;
	localparam logic [7:0] ADR_STAT   = 8'h14;
	localparam logic [7:0] ADR_IRQ    = 8'h18;
	localparam logic [7:0] ADR_MASK   = 8'h1C;
	localparam logic [7:0] ADR_VALUE  = 8'h20;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] CH_RST    = 32'h0000_0000;
	localparam logic [31:0] MASK_RST  = 32'h0000_0000;
	// Interrupt bit positions.
	localparam int IRQ_VAL = 0;
	localparam int IRQ_CH0 = 1;
	localparam int IRQ_CH1 = 2;

	typedef enum logic [1:0] {
		ITM_CH_NONE = 2'h0, ITM_CH_ONE = 2'h1, ITM_CH_TWO = 2'h2
	} itm_chsel_t;

	typedef enum logic [1:0] {
		ITM_EXT_NONE = 2'h0, ITM_EXT_16 = 2'h1, ITM_EXT_8 = 2'h2
	} itm_ext_t;

	// Telegram chosen for a crossing: a state, or none at all.
	typedef enum logic [1:0] {
		ITM_TG_ON = 2'h0, ITM_TG_OFF = 2'h1, ITM_TG_NONE = 2'h2
	} itm_tg_t;

	typedef struct packed {
		logic [6:0] cycleCnt;
		logic       sendChange;
		logic [3:0] offDelay;
		logic [3:0] onDelay;
		itm_ext_t   extSel;
		itm_tg_t    backTg;
		itm_tg_t    fwdTg;
		logic       falling;
		logic [1:0] hystSel;
		logic [3:0] levelSel;
	} itm_chcfg_t;

	typedef struct packed {
		logic       valid;
		logic       bitValue;
	} itm_tgram_t;

	// Delay selection index to seconds.
	function automatic logic [11:0] itm_delay_s(input logic [3:0] sel);
		case (sel)
			4'h0: itm_delay_s = 12'd0;
			4'h1: itm_delay_s = 12'd1;
			4'h2: itm_delay_s = 12'd3;
			4'h3: itm_delay_s = 12'd5;
			4'h4: itm_delay_s = 12'd10;
			4'h5: itm_delay_s = 12'd15;
			4'h6: itm_delay_s = 12'd30;
			4'h7: itm_delay_s = 12'd60;
			4'h8: itm_delay_s = 12'd180;
			4'h9: itm_delay_s = 12'd300;
			4'hA: itm_delay_s = 12'd600;
			4'hB: itm_delay_s = 12'd900;
			4'hC: itm_delay_s = 12'd1800;
			4'hD: itm_delay_s = 12'd3600;
			default: itm_delay_s = 12'd3600;
		endcase
	endfunction
endpackage
